// ---- src/tps_regs.vh ----
// constants for the three rail power sequencer
`ifndef TPS_REGS_VH
`define TPS_REGS_VH
// timing clock: 120 us per nF of timing capacitance, period in ns
`define TPS_US_PER_NF        120
`define TPS_CAP_NF           10
`define TPS_SYS_PERIOD_NS    4
`define TPS_TCLK_NS          (`TPS_US_PER_NF * `TPS_CAP_NF * 1000)
`define TPS_TCLK_CYCLES      (`TPS_TCLK_NS / `TPS_SYS_PERIOD_NS)
// counts in timing clock periods
`define TPS_FIRST_TICKS      4'h9
`define TPS_STEP_TICKS       4'h8
`define TPS_SYNC_TICKS       4'h2
`define TPS_CNT_W            4
`endif

// ---- src/tps_tick_div.v ----
// timing clock divider producing a one-cycle tick enable
`timescale 1ns/10ps
module tps_tick_div #(
   parameter [31:0] DIVIDE = 32'd300000
) (
   // clock and reset
   input  wire clk_sys,
   input  wire reset_n,
   // tick out
   output reg  tick
);
   reg [31:0] count;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         count <= 32'h0;
         tick  <= 1'b0;
      end else if (count == DIVIDE - 32'd1) begin
         count <= 32'h0;
         tick  <= 1'b1;
      end else begin
         count <= count + 32'd1;
         tick  <= 1'b0;
      end
   end
endmodule // tps_tick_div

// ---- src/tps_sequencer.v ----
// three rail power sequencer core
`timescale 1ns/10ps
`include "tps_regs.vh"
// How it works
// RULE_01 - after reset all three outputs stay inactive until the request is seen high; with polarity select high they are active until the first clock edge.
// RULE_02 - the first output is released nine to ten timing periods after the request rises.
// RULE_03 - the second output is released exactly eight timing periods after the first.
// RULE_04 - the third output is released exactly eight timing periods after the second.
// RULE_05 - on request removal the outputs fall back in order third, second, first.
// RULE_06 - the third falls nine to ten periods after removal, the others eight apart.
// RULE_07 - removal before the first release clears the count and leaves all outputs off.
// RULE_08 - removal after the first release but before completion shuts down in reverse.
// RULE_09 - the polarity select inverts all outputs; low means a released output is high.
// RULE_10 - the system must hold the polarity select at a defined level, never floating.
// RULE_11 - the timing period is 120 us per nF of timing capacitance, 1.2 ms at 10 nF.
// RULE_12 - with polarity select high a released output is driven low.
// RULE_13 - the request passes a two-stage synchroniser before the sequencer uses it.
module tps_sequencer #(
   parameter [31:0] TCLK_CYCLES = `TPS_TCLK_CYCLES
) (
   // clock and reset
   input  wire clk_sys,
   input  wire reset_n,
   // control inputs
   input  wire sequence_request,
   input  wire polarity_select,
   // open-drain rail outputs, pin level and pull-down enable
   output reg  first_rail_output,
   output reg  first_rail_output_oe,
   output reg  second_rail_output,
   output reg  second_rail_output_oe,
   output reg  third_rail_output,
   output reg  third_rail_output_oe,
   // timing clock waveform indicator
   output reg  timing_cap_node
);
   // ****************************************
   // states
   // ****************************************
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_UP1  = 3'h1;
   localparam [2:0] ST_UP2  = 3'h2;
   localparam [2:0] ST_UP3  = 3'h3;
   localparam [2:0] ST_ON   = 3'h4;
   localparam [2:0] ST_DN3  = 3'h5;
   localparam [2:0] ST_DN2  = 3'h6;
   localparam [2:0] ST_DN1  = 3'h7;
   // idle -> up1 (first delay) -> up2 -> up3 -> on
   // on -> dn3 -> dn2 -> dn1 -> idle; an abort in up2 or up3 joins the down path

   reg  [2:0]              state;
   reg  [2:0]              next_state;
   reg  [`TPS_CNT_W-1:0]   count;
   reg  [`TPS_CNT_W-1:0]   next_count;
   reg  [2:0]              rails;
   reg  [2:0]              next_rails;
   reg  [2:0]              next_pull;
   reg                     req_meta;
   reg                     req_sync;
   wire                    tick;

   // counter reloads; the first one gives back the ticks the synchroniser used
   localparam [`TPS_CNT_W-1:0] LOAD_FIRST = `TPS_FIRST_TICKS - `TPS_SYNC_TICKS - 4'h1;
   localparam [`TPS_CNT_W-1:0] LOAD_STEP  = `TPS_STEP_TICKS - 4'h1;

   // ****************************************
   // timing clock
   // ****************************************
   // the capacitor oscillator is stood in for by a divider of the system clock
   tps_tick_div #(.DIVIDE(TCLK_CYCLES)) u_div ( // RULE_11
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .tick    (tick)
   );

   // ****************************************
   // request synchroniser
   // ****************************************
   // stages advance on ticks only, so the phase of the request against the
   // timing clock is what spreads the first delay over nine to ten periods
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         req_meta <= 1'b0;
         req_sync <= 1'b0;
      end else if (tick) begin
         req_meta <= sequence_request; // RULE_13
         req_sync <= req_meta;         // RULE_13
      end
   end

   // ****************************************
   // sequencer
   // ****************************************
   // the count runs only on ticks; between ticks every register holds
   always @* begin
      next_state = state;
      next_count = count;
      next_rails = rails;
      if (tick) begin
         case (state)
            ST_IDLE: begin
               next_rails = 3'h0; // RULE_01
               next_count = 4'h0;
               if (req_sync) begin
                  next_state = ST_UP1;
                  next_count = LOAD_FIRST; // RULE_02
               end
            end
            ST_UP1: begin
               if (!req_sync) begin
                  next_state = ST_IDLE; // RULE_07
                  next_count = 4'h0;
               end else if (count == 4'h0) begin
                  next_rails = 3'h1; // RULE_02
                  next_state = ST_UP2;
                  next_count = LOAD_STEP;
               end else begin
                  next_count = count - 4'h1;
               end
            end
            ST_UP2: begin
               if (!req_sync) begin
                  // only the first rail is out; it alone goes back down
                  next_state = ST_DN1; // RULE_08
                  next_count = LOAD_FIRST;
               end else if (count == 4'h0) begin
                  next_rails = 3'h3; // RULE_03
                  next_state = ST_UP3;
                  next_count = LOAD_STEP;
               end else begin
                  next_count = count - 4'h1;
               end
            end
            ST_UP3: begin
               if (!req_sync) begin
                  // two rails are out; the second falls first
                  next_state = ST_DN2; // RULE_08
                  next_count = LOAD_FIRST;
               end else if (count == 4'h0) begin
                  next_rails = 3'h7; // RULE_04
                  next_state = ST_ON;
                  next_count = LOAD_STEP;
               end else begin
                  next_count = count - 4'h1;
               end
            end
            ST_ON: begin
               // hold every rail until the request is removed
               if (!req_sync) begin
                  next_state = ST_DN3; // RULE_05
                  next_count = LOAD_FIRST; // RULE_06
               end
            end
            ST_DN3, ST_DN2, ST_DN1: begin
               // a new request is ignored until the shutdown reaches idle
               if (count == 4'h0) begin
                  next_rails = {1'b0, rails[2:1]}; // RULE_05 RULE_06
                  next_state = (state == ST_DN1) ? ST_IDLE : state + 3'h1;
                  next_count = LOAD_STEP;
               end else begin
                  next_count = count - 4'h1;
               end
            end
            default: begin
               next_state = ST_IDLE;
               next_count = 4'h0;
               next_rails = 3'h0;
            end
         endcase
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         count <= 4'h0;
         rails <= 3'h0;
      end else begin
         state <= next_state;
         count <= next_count;
         rails <= next_rails;
      end
   end

   // ****************************************
   // output drive
   // ****************************************
   // released level xor polarity; pull-down whenever the pin must read low
   always @* begin
      next_pull = ~(next_rails ^ {3{polarity_select}}); // RULE_09 RULE_12
   end

   // open-drain data stays zero, only the enables move the pins; reset pulls
   // every pin low, so an active-low regulator sees enable until the first
   // edge after release
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         first_rail_output     <= 1'b0;
         first_rail_output_oe  <= 1'b1;
         second_rail_output    <= 1'b0;
         second_rail_output_oe <= 1'b1;
         third_rail_output     <= 1'b0;
         third_rail_output_oe  <= 1'b1;
         timing_cap_node       <= 1'b0;
      end else begin
         first_rail_output     <= 1'b0;
         second_rail_output    <= 1'b0;
         third_rail_output     <= 1'b0;
         first_rail_output_oe  <= next_pull[0]; // RULE_09 RULE_12
         second_rail_output_oe <= next_pull[1]; // RULE_09 RULE_12
         third_rail_output_oe  <= next_pull[2]; // RULE_09 RULE_12
         if (tick) begin
            timing_cap_node <= ~timing_cap_node;
         end
      end
   end
endmodule // tps_sequencer

// ---- tb/tps_seq_asserts.sv ----
// port checker for the rail sequencer
`timescale 1ns/10ps
module tps_seq_asserts #(
   parameter [31:0] TCLK_CYCLES = 32'd4
) (
   // clock and reset
   input wire clk_sys,
   input wire reset_n,
   // controls
   input wire sequence_request,
   input wire polarity_select,
   // rail pins
   input wire first_rail_output,
   input wire first_rail_output_oe,
   input wire second_rail_output,
   input wire second_rail_output_oe,
   input wire third_rail_output,
   input wire third_rail_output_oe,
   input wire timing_cap_node
);
   localparam int S = 8 * TCLK_CYCLES;
   localparam int S1 = S + 1;
   logic [1:0] rdy;
   logic        cap_q;
   logic        seen;
   logic [31:0] since;
   // released state of each rail, whatever the polarity
   wire [2:0] r = ~{third_rail_output_oe, second_rail_output_oe, first_rail_output_oe}
                  ^ {3{polarity_select}};
   // oe holds its reset value one edge after release
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) rdy <= 2'h0;
      else rdy <= {rdy[0], 1'b1};
   end
   // cycles between two edges of the timing wave
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cap_q <= 1'b0;
         seen  <= 1'b0;
         since <= 32'h0;
      end else begin
         cap_q <= timing_cap_node;
         if (timing_cap_node != cap_q) begin
            seen  <= 1'b1;
            since <= 32'h1;
         end else begin
            since <= since + 32'h1;
         end
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // ****************
   // checks
   // ****************
   up_order_a: assert property (rdy[1] |-> (!r[1] || r[0]) && (!r[2] || r[1]))
      else $error("rail released out of order");
   up_first_step_a: assert property (rdy[1] && $rose(r[1]) |-> $past(r[0], S) && !$past(r[0], S1))
      else $error("second rail spacing wrong");
   up_second_step_a: assert property (rdy[1] && $rose(r[2]) |-> $past(r[1], S) && !$past(r[1], S1))
      else $error("third rail spacing wrong");
   down_order_a: assert property (rdy[1] && ($fell(r[1]) || $fell(r[0])) |-> !r[2] && (!r[1] || !$fell(r[0])))
      else $error("rail dropped out of order");
   rise_cause_a: assert property (rdy[1] && $rose(r[0]) |-> $past(sequence_request, S1))
      else $error("first rail released without request");
   fall_cause_a: assert property (rdy[1] && $fell(r[2]) |-> !$past(sequence_request, S1))
      else $error("third rail dropped without removal");
   drain_only_a: assert property (!first_rail_output && !second_rail_output && !third_rail_output)
      else $error("open-drain data not low");
   cap_period_a: assert property (rdy[1] && seen && $changed(timing_cap_node) |-> since == TCLK_CYCLES)
      else $error("timing wave period wrong");
endmodule // tps_seq_asserts
bind tps_sequencer tps_seq_asserts #(.TCLK_CYCLES(TCLK_CYCLES)) tps_seq_asserts_inst (
   .clk_sys(clk_sys), .reset_n(reset_n), .sequence_request(sequence_request),
   .polarity_select(polarity_select), .first_rail_output(first_rail_output),
   .first_rail_output_oe(first_rail_output_oe), .second_rail_output(second_rail_output),
   .second_rail_output_oe(second_rail_output_oe), .third_rail_output(third_rail_output),
   .third_rail_output_oe(third_rail_output_oe), .timing_cap_node(timing_cap_node));

// ---- tb/tps_reg_model.sv ----
// regulator enables seen through the pulled-up rail pins
`timescale 1ns/10ps
module tps_reg_model (
   // pull-down enables and polarity
   input  wire       first_rail_output_oe,
   input  wire       second_rail_output_oe,
   input  wire       third_rail_output_oe,
   input  wire       polarity_select,
   // regulator on state
   output wire [2:0] reg_on
);
   // pull-up wins whenever the pin is not pulled down
   wire [2:0] pin = ~{third_rail_output_oe, second_rail_output_oe, first_rail_output_oe};
   assign reg_on = pin ^ {3{polarity_select}};
endmodule // tps_reg_model

// ---- tb/tps_sequencer_tb_top.sv ----
// testbench for the rail sequencer
`timescale 1ns/10ps
module tps_sequencer_tb_top;
   logic        clk_sys = 0, reset_n = 0, sequence_request = 0, polarity_select = 0;
   wire         d1, o1, d2, o2, d3, o3, cap;
   wire  [2:0]  on;
   int          err_count = 0, n_checks = 0, n;
   logic [31:0] seed = 32'h1464;
   logic        cap_prev;
   always #2 clk_sys = ~clk_sys;
   tps_sequencer #(.TCLK_CYCLES(32'd4)) tps_sequencer_inst (.clk_sys(clk_sys),
      .reset_n(reset_n), .sequence_request(sequence_request),
      .polarity_select(polarity_select), .first_rail_output(d1), .first_rail_output_oe(o1),
      .second_rail_output(d2), .second_rail_output_oe(o2), .third_rail_output(d3),
      .third_rail_output_oe(o3), .timing_cap_node(cap));
   tps_reg_model tps_reg_model_inst (.first_rail_output_oe(o1), .second_rail_output_oe(o2),
      .third_rail_output_oe(o3), .polarity_select(polarity_select), .reg_on(on));
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask
   task close_out;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // bounded wait for rail k to reach v, cycles counted in n
   task wt(input int k, input logic v, input int lim);
      n = 0;
      while (on[k] !== v && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= lim) begin
         err_count++;
         close_out;
      end
   endtask
   // random phase of the request against the timing tick
   task phase;
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      repeat (seed[1:0] + 1) @(posedge clk_sys);
   endtask
   task rst(input logic p);
      @(posedge clk_sys);
      reset_n <= 0;
      polarity_select <= p;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1;
      repeat (12) @(negedge clk_sys);
      chk("idle", on, 0);
      chk("oe", {o3, o2, o1}, {3{~p}});
      chk("drain", {d3, d2, d1}, 0);
      cap_prev = cap;
      repeat (4) @(negedge clk_sys);
      chk("cap", cap ^ cap_prev, 1);
   endtask
   task up;
      phase;
      sequence_request <= 1;
      wt(0, 1, 60);
      chk("d1", n >= 34 && n <= 42, 1);
      wt(1, 1, 40);
      chk("d2", n, 32);
      wt(2, 1, 40);
      chk("d3", n, 32);
   endtask
   task down;
      phase;
      sequence_request <= 0;
      wt(2, 0, 60);
      chk("d4", n >= 34 && n <= 42, 1);
      chk("ord", on, 3);
      wt(1, 0, 40);
      chk("d5", n, 32);
      wt(0, 0, 40);
      chk("d6", n, 32);
   endtask
   initial begin
      rst(0);
      phase;
      sequence_request <= 1;
      repeat (8 + seed[4:2]) @(posedge clk_sys);
      sequence_request <= 0;
      repeat (60) @(negedge clk_sys);
      chk("glitch", on, 0);
      up;
      down;
      phase;
      sequence_request <= 1;
      wt(0, 1, 60);
      repeat (8) @(posedge clk_sys);
      sequence_request <= 0;
      wt(0, 0, 60);
      chk("abort", n >= 34 && n <= 42 && on === 0, 1);
      phase;
      sequence_request <= 1;
      wt(0, 1, 60);
      wt(1, 1, 40);
      repeat (8) @(posedge clk_sys);
      sequence_request <= 0;
      wt(1, 0, 60);
      chk("abort2", n >= 34 && n <= 42 && on === 1, 1);
      wt(0, 0, 40);
      chk("abort3", n, 32);
      rst(1);
      up;
      down;
      close_out;
   end
endmodule // tps_sequencer_tb_top
